/* logic/zv_regs_pkg.sv */
// Package: offsets, field positions, reset values and carrier types of the register group
package zv_regs_pkg;

    // ==========================================================
    // Register offsets in configuration space
    localparam logic [7:0] OFS_VIDEO_CTRL = 8'h84;
    localparam logic [7:0] OFS_LOADER_STAT = 8'h85;
    localparam logic [7:0] OFS_PIN0_CTRL = 8'h88;
    localparam logic [0:0] FUNC_ZERO = 1'h0;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_VIDEO_CTRL = 8'h00;
    localparam logic [7:0] RST_LOADER_STAT = 8'h00;
    localparam logic [7:0] RST_PIN0_CTRL = 8'h80;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // Field positions of the zoom-video routing control register
    localparam int VC_OUT_EN = 7;
    localparam int VC_SOCK_SEL = 6;
    localparam int VC_AUTO = 5;
    localparam int VC_PRIO_HI = 4;
    localparam int VC_PRIO_LO = 2;
    localparam int VC_S1_MODE = 1;
    localparam int VC_S0_MODE = 0;

    // Field positions of the loader status register
    localparam int LS_PRESENT = 2;
    localparam int LS_ERROR = 1;
    localparam int LS_BUSY = 0;

    // Field positions of the pin 0 control register
    localparam int P0_MODE_HI = 7;
    localparam int P0_MODE_LO = 6;
    localparam int P0_IRQ_EN = 4;
    localparam int P0_FLAG = 3;
    localparam int P0_OUT = 1;
    localparam int P0_IN = 0;
    // Bits that plain writes store (mode, interrupt enable, output value)
    localparam logic [7:0] P0_WRITE_MASK = 8'hd2;

    // ==========================================================
    // Priority codes of the auto-detect field
    localparam logic [2:0] PRIO_A_B_X = 3'h0;
    localparam logic [2:0] PRIO_A_X_B = 3'h1;
    localparam logic [2:0] PRIO_B_A_X = 3'h2;
    localparam logic [2:0] PRIO_B_X_A = 3'h3;
    localparam logic [2:0] PRIO_X_A_B = 3'h4;
    localparam logic [2:0] PRIO_X_B_A = 3'h5;

    // Pin 0 function modes
    typedef enum logic [1:0] {
        MODE_ACTIVITY = 2'h0,
        MODE_VIDEO_STAT = 2'h1,
        MODE_INPUT = 2'h2,
        MODE_OUTPUT = 2'h3
    } pin_mode_t;

    // Video sources; the code indexes the availability vector
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_A = 2'h1,
        SRC_B = 2'h2,
        SRC_EXT = 2'h3
    } video_src_t;

    // One configuration access, taken in a single cycle
    typedef struct packed {
        logic [0:0] func;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cfg_req_t;

endpackage

/* logic/pin_sync3.sv */
// Three-stage pin synchroniser whose output moves only once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;
    logic [W-1:0] stage3_reg;

    // ==========================================================
    // Stage one is read only by stage two, to contain metastability
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
        end else begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
        end
    end

    // Per bit, accept the new level once it has held for two samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    level_out[i] <= stage3_reg[i];
                end
            end
        end
    end

endmodule

/* logic/video_mux_eeprom_gpio_regs.sv */
// Video routing, loader status and pin 0 control registers of the dual-socket controller
//
// Overview of operation
// - Video output enable low tristates the external video port; high drives it when socket 0 or 1 video is routed.
// - Socket select picks socket 0 or 1 video, only when its mode is enabled.
// - Bit 5 turns video auto-detect on or off; reset leaves it off.
// - Priority field orders sources A, B, external; used only under auto-detect.
// - Socket 1 video mode takes its video in and drops our socket drivers.
// - Socket 0 video mode takes its video in and drops our socket drivers.
// - Video control at 84h in both functions, all bits read-write, resets 00h.
// - Loader status at 85h in function 0 only; bits 7 to 3 read zero.
// - Data error bit sets on a loader error; writing 1 clears it.
// - Busy bit reads 1 while the loader fetches the identification value.
// - Pin 0 control at 88h in both functions, resets to 80h (input).
// - Pin mode: activity, video status, general input, general output.
// - Video status mode drives whether the video output is enabled.
// - Change flag sets on input change in input mode; write 1 clears.
// - Interrupt enable with change flag raises the card status change interrupt.
// - Output mode drives the pin with the stored output value.
// - Input value bit follows the pin level in every pin mode.
// - Bits 5 and 2 of pin 0 control read zero and ignore writes.
// - Only the global reset returns these bits to their defaults.
`timescale 1ns/1ps
module video_mux_eeprom_gpio_regs #(
    parameter int ZV_W = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input zv_regs_pkg::cfg_req_t CFG_REQ,
    output logic [7:0] CFG_RDATA,
    output logic CFG_RVALID,
    input wire logic [ZV_W-1:0] SOCK0_ZV_IN,
    input wire logic [ZV_W-1:0] SOCK1_ZV_IN,
    input wire logic SOCK0_ZV_PRESENT,
    input wire logic SOCK1_ZV_PRESENT,
    input wire logic EXT_ZV_PRESENT,
    output logic SOCK0_ZV_DRIVE_OE,
    output logic SOCK1_ZV_DRIVE_OE,
    output logic [ZV_W-1:0] ZV_OUT,
    output logic ZV_OUT_OE,
    input wire logic EEPROM_PRESENT,
    input wire logic EEPROM_ERROR,
    input wire logic EEPROM_BUSY,
    input wire logic SOCK0_ACTIVITY,
    input wire logic PIN0_IN,
    output logic PIN0_OUT,
    output logic PIN0_OE,
    output logic CARD_STATUS_CHANGE
);
    import zv_regs_pkg::*;

    logic [7:0] video_ctrl_reg;
    logic eeprom_data_error_reg;
    logic [7:0] pin0_ctrl_reg;
    logic pin0_change_flag_reg;
    logic pin0_input_value_reg;
    logic [3:0] sync_level;
    logic pin_sync;
    logic s0_present;
    logic s1_present;
    logic ext_present;
    logic wr_video;
    logic wr_status;
    logic wr_pin0;
    logic video_output_enable;
    logic video_socket_select;
    logic auto_detect;
    logic [2:0] prio_code;
    logic socket1_video_mode;
    logic socket0_video_mode;
    pin_mode_t pin0_mode;
    logic pin0_interrupt_enable;
    logic pin0_output_value;
    logic pin_changed;
    video_src_t src_next;
    logic [3:0] avail;
    logic [ZV_W-1:0] zv_next;
    logic zv_oe_next;
    logic [7:0] status_view;
    logic [7:0] pin0_view;

    // ==========================================================
    // Pin synchroniser for the general pin and the video presence lines
    pin_sync3 #(
        .W(4)
    ) u_pin_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .pin_in({EXT_ZV_PRESENT, SOCK1_ZV_PRESENT, SOCK0_ZV_PRESENT, PIN0_IN}),
        .level_out(sync_level)
    );
    assign pin_sync = sync_level[0];
    assign s0_present = sync_level[1];
    assign s1_present = sync_level[2];
    assign ext_present = sync_level[3];

    // ==========================================================
    // Access decode; the loader status exists in function 0 only
    assign wr_video = CFG_REQ.wr && (CFG_REQ.addr == OFS_VIDEO_CTRL);
    assign wr_status = CFG_REQ.wr && (CFG_REQ.addr == OFS_LOADER_STAT)
        && (CFG_REQ.func == FUNC_ZERO);
    assign wr_pin0 = CFG_REQ.wr && (CFG_REQ.addr == OFS_PIN0_CTRL);

    // Field views of the stored controls
    assign video_output_enable = video_ctrl_reg[VC_OUT_EN];
    assign video_socket_select = video_ctrl_reg[VC_SOCK_SEL];
    assign auto_detect = video_ctrl_reg[VC_AUTO];
    assign prio_code = video_ctrl_reg[VC_PRIO_HI:VC_PRIO_LO];
    assign socket1_video_mode = video_ctrl_reg[VC_S1_MODE];
    assign socket0_video_mode = video_ctrl_reg[VC_S0_MODE];
    assign pin0_mode = pin_mode_t'(pin0_ctrl_reg[P0_MODE_HI:P0_MODE_LO]);
    assign pin0_interrupt_enable = pin0_ctrl_reg[P0_IRQ_EN];
    assign pin0_output_value = pin0_ctrl_reg[P0_OUT];

    // ==========================================================
    // Video routing control; only the global reset clears it
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            video_ctrl_reg <= RST_VIDEO_CTRL;
        end else if (wr_video) begin
            video_ctrl_reg <= CFG_REQ.wdata;
        end
    end

    // Socket terminal drivers go quiet while a card supplies video
    assign SOCK0_ZV_DRIVE_OE = !socket0_video_mode;
    assign SOCK1_ZV_DRIVE_OE = !socket1_video_mode;

    // First available source in a three-entry order
    function automatic video_src_t first_avail(input video_src_t a, input video_src_t b,
                                               input video_src_t c, input logic [3:0] av);
        video_src_t r;
        r = SRC_NONE;
        if (av[a]) begin
            r = a;
        end else if (av[b]) begin
            r = b;
        end else if (av[c]) begin
            r = c;
        end
        return r;
    endfunction

    // ==========================================================
    // Source choice: fixed select, or ranked search under auto-detect
    assign avail = {ext_present, socket1_video_mode && s1_present,
                    socket0_video_mode && s0_present, 1'b0};
    always_comb begin
        src_next = SRC_NONE;
        if (auto_detect) begin
            case (prio_code)
                PRIO_A_B_X: src_next = first_avail(SRC_A, SRC_B, SRC_EXT, avail);
                PRIO_A_X_B: src_next = first_avail(SRC_A, SRC_EXT, SRC_B, avail);
                PRIO_B_A_X: src_next = first_avail(SRC_B, SRC_A, SRC_EXT, avail);
                PRIO_B_X_A: src_next = first_avail(SRC_B, SRC_EXT, SRC_A, avail);
                PRIO_X_A_B: src_next = first_avail(SRC_EXT, SRC_A, SRC_B, avail);
                PRIO_X_B_A: src_next = first_avail(SRC_EXT, SRC_B, SRC_A, avail);
                default: src_next = SRC_NONE; // Reserved codes route nothing
            endcase
        end else if (video_socket_select) begin
            src_next = socket1_video_mode ? SRC_B : SRC_NONE;
        end else begin
            src_next = socket0_video_mode ? SRC_A : SRC_NONE;
        end
    end

    // An external winner owns the port itself, so we stay off it
    always_comb begin
        zv_next = '0;
        zv_oe_next = 1'b0;
        case (src_next)
            SRC_A: zv_next = SOCK0_ZV_IN;
            SRC_B: zv_next = SOCK1_ZV_IN;
            default: zv_next = '0;
        endcase
        if (video_output_enable && (src_next == SRC_A || src_next == SRC_B)) begin
            zv_oe_next = 1'b1;
        end
    end

    // Video data is retimed once; pixel lanes are not synchronised, the card's
    // video clock is expected to be slow against the bus clock
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ZV_OUT <= '0;
            ZV_OUT_OE <= 1'b0;
        end else begin
            ZV_OUT <= zv_next;
            ZV_OUT_OE <= zv_oe_next;
        end
    end

    // ==========================================================
    // Loader error: a new error wins over a clearing write
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            eeprom_data_error_reg <= RST_LOADER_STAT[LS_ERROR];
        end else if (EEPROM_ERROR) begin
            eeprom_data_error_reg <= 1'b1;
        end else if (wr_status && CFG_REQ.wdata[LS_ERROR]) begin
            eeprom_data_error_reg <= 1'b0;
        end
    end

    // Upper bits stay zero; present and busy come straight from the loader
    always_comb begin
        status_view = 8'h00;
        status_view[LS_PRESENT] = EEPROM_PRESENT;
        status_view[LS_ERROR] = eeprom_data_error_reg;
        status_view[LS_BUSY] = EEPROM_BUSY;
    end

    // ==========================================================
    // Pin 0 control: mode, interrupt enable and output value
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin0_ctrl_reg <= RST_PIN0_CTRL;
        end else if (wr_pin0) begin
            pin0_ctrl_reg <= CFG_REQ.wdata & P0_WRITE_MASK;
        end
    end

    // Input value follows the settled pin level continuously
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin0_input_value_reg <= RST_PIN0_CTRL[P0_IN];
        end else begin
            pin0_input_value_reg <= pin_sync;
        end
    end

    // Change flag catches glitches software would miss; set beats clear
    assign pin_changed = (pin0_mode == MODE_INPUT) && (pin_sync != pin0_input_value_reg);
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin0_change_flag_reg <= RST_PIN0_CTRL[P0_FLAG];
        end else if (pin_changed) begin
            pin0_change_flag_reg <= 1'b1;
        end else if (wr_pin0 && CFG_REQ.wdata[P0_FLAG]) begin
            pin0_change_flag_reg <= 1'b0;
        end
    end

    assign CARD_STATUS_CHANGE = pin0_interrupt_enable && pin0_change_flag_reg;

    // Pin driver per mode
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            PIN0_OUT <= 1'b0;
            PIN0_OE <= 1'b0;
        end else begin
            case (pin0_mode)
                MODE_ACTIVITY: begin
                    PIN0_OUT <= SOCK0_ACTIVITY;
                    PIN0_OE <= 1'b1;
                end
                MODE_VIDEO_STAT: begin
                    PIN0_OUT <= ZV_OUT_OE;
                    PIN0_OE <= 1'b1;
                end
                MODE_OUTPUT: begin
                    PIN0_OUT <= pin0_output_value;
                    PIN0_OE <= 1'b1;
                end
                default: begin
                    PIN0_OUT <= 1'b0;
                    PIN0_OE <= 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        pin0_view = pin0_ctrl_reg;
        pin0_view[P0_FLAG] = pin0_change_flag_reg;
        pin0_view[P0_IN] = pin0_input_value_reg;
    end

    // ==========================================================
    // Read port: data one cycle after the request
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CFG_RDATA <= UNMAPPED_READ;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= CFG_REQ.rd;
            if (CFG_REQ.rd) begin
                if (CFG_REQ.addr == OFS_VIDEO_CTRL) begin
                    CFG_RDATA <= video_ctrl_reg;
                end else if (CFG_REQ.addr == OFS_LOADER_STAT && CFG_REQ.func == FUNC_ZERO) begin
                    CFG_RDATA <= status_view;
                end else if (CFG_REQ.addr == OFS_PIN0_CTRL) begin
                    CFG_RDATA <= pin0_view;
                end else begin
                    CFG_RDATA <= UNMAPPED_READ;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_clear_flag;
        wr_pin0 && CFG_REQ.wdata[P0_FLAG] && !pin_changed;
    endsequence
    sequence s_read_status;
        CFG_REQ.rd && CFG_REQ.addr == OFS_LOADER_STAT && CFG_REQ.func == FUNC_ZERO;
    endsequence

    a_video_oe_gate: assert property (ZV_OUT_OE |-> $past(video_output_enable))
        else $error("video port driven while output disabled");
    a_manual_select: assert property (!auto_detect && video_output_enable
        && video_socket_select && socket1_video_mode |=> ZV_OUT_OE && ZV_OUT == $past(SOCK1_ZV_IN))
        else $error("socket 1 video not routed");
    a_ext_priority: assert property (auto_detect && prio_code == PRIO_X_A_B && ext_present
        |=> !ZV_OUT_OE)
        else $error("external source did not take the port");
    a_sock_drivers: assert property (SOCK0_ZV_DRIVE_OE != socket0_video_mode
        && SOCK1_ZV_DRIVE_OE != socket1_video_mode)
        else $error("socket video drivers not released");
    a_status_upper: assert property (s_read_status |=> CFG_RDATA[7:3] == 5'h00
        && CFG_RDATA[LS_BUSY] == $past(EEPROM_BUSY))
        else $error("loader status read wrong");
    a_error_sticky: assert property (EEPROM_ERROR |=> eeprom_data_error_reg ##1
        (eeprom_data_error_reg || $past(wr_status && CFG_REQ.wdata[LS_ERROR])))
        else $error("loader error lost");
    a_flag_set: assert property (pin_changed |=> pin0_change_flag_reg)
        else $error("pin change not flagged");
    a_flag_clear: assert property (pin0_change_flag_reg
        && !(wr_pin0 && CFG_REQ.wdata[P0_FLAG] && !pin_changed)
        |=> pin0_change_flag_reg)
        else $error("change flag dropped without a clear");
    a_flag_wipe: assert property (s_clear_flag |=> !pin0_change_flag_reg)
        else $error("change flag not cleared by write");
    a_irq_level: assert property (CARD_STATUS_CHANGE == (pin0_ctrl_reg[P0_IRQ_EN]
        && pin0_change_flag_reg))
        else $error("interrupt does not match enable and flag");
    a_gpo_drive: assert property (pin0_mode == MODE_OUTPUT |=> PIN0_OE
        && PIN0_OUT == $past(pin0_output_value))
        else $error("pin not driven with output value");
    a_reserved_pin: assert property (CFG_REQ.rd && CFG_REQ.addr == OFS_PIN0_CTRL
        |=> !CFG_RDATA[5] && !CFG_RDATA[2])
        else $error("reserved pin bits read nonzero");

endmodule

/* testbench/far_side_model.sv */
// Far-side model: card sockets, external video source and the wire of pin 0
`timescale 1ns/1ps
module far_side_model #(
    parameter logic [15:0] S0_PAT = 16'h3c5a,
    parameter logic [15:0] S1_PAT = 16'ha5c3
) (
    input wire logic clk,
    input wire logic [2:0] pres_cmd,
    input wire logic pin_drive,
    input wire logic pin_level,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic [15:0] s0_data,
    output logic [15:0] s1_data,
    output logic s0_pres,
    output logic s1_pres,
    output logic x_pres,
    output logic pin_in
);
    // =====================================================
    // Sources
    // Distinct fixed patterns so a wrong route shows at once
    assign s0_data = S0_PAT;
    assign s1_data = S1_PAT;

    // Presence levels move on the clock like a card's own logic
    always_ff @(posedge clk) begin
        {x_pres, s1_pres, s0_pres} <= pres_cmd;
    end

    // =====================================================
    // Pin wire
    // Pull-down when nobody drives, so a released pin never holds its last level
    assign pin_in = pin_oe ? pin_out : (pin_drive ? pin_level : 1'b0);
endmodule

/* testbench/test_video_mux_eeprom_gpio_regs.sv */
// Self-checking bench for the video routing, loader status and pin 0 registers
`timescale 1ns/1ps
module test_video_mux_eeprom_gpio_regs;
    import zv_regs_pkg::*;
    localparam logic [15:0] S0_PAT = 16'h3c5a;
    localparam logic [15:0] S1_PAT = 16'ha5c3;
    logic sys_clk;
    logic rst;
    cfg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] s0_data;
    logic [15:0] s1_data;
    logic [15:0] zv_out;
    logic s0_pres, s1_pres, x_pres, s0_oe, s1_oe, zv_oe;
    logic ee_present, ee_error, ee_busy, activity;
    logic pin_in, pin_out, pin_oe, card_status_change, pin_drive, pin_level;
    logic [2:0] pres_cmd;
    int num_errors = 0;
    int compares = 0;

    // =====================================================
    // Design and far side
    video_mux_eeprom_gpio_regs #(.ZV_W(16)) i_dut (
        .SYS_CLK(sys_clk), .RST(rst), .CFG_REQ(req), .CFG_RDATA(rdata),
        .CFG_RVALID(rvalid), .SOCK0_ZV_IN(s0_data), .SOCK1_ZV_IN(s1_data),
        .SOCK0_ZV_PRESENT(s0_pres), .SOCK1_ZV_PRESENT(s1_pres), .EXT_ZV_PRESENT(x_pres),
        .SOCK0_ZV_DRIVE_OE(s0_oe), .SOCK1_ZV_DRIVE_OE(s1_oe), .ZV_OUT(zv_out),
        .ZV_OUT_OE(zv_oe), .EEPROM_PRESENT(ee_present), .EEPROM_ERROR(ee_error),
        .EEPROM_BUSY(ee_busy), .SOCK0_ACTIVITY(activity), .PIN0_IN(pin_in),
        .PIN0_OUT(pin_out), .PIN0_OE(pin_oe), .CARD_STATUS_CHANGE(card_status_change)
    );
    far_side_model #(.S0_PAT(S0_PAT), .S1_PAT(S1_PAT)) i_far (
        .clk(sys_clk), .pres_cmd(pres_cmd), .pin_drive(pin_drive), .pin_level(pin_level),
        .pin_oe(pin_oe), .pin_out(pin_out), .s0_data(s0_data), .s1_data(s1_data),
        .s0_pres(s0_pres), .s1_pres(s1_pres), .x_pres(x_pres), .pin_in(pin_in)
    );

    // =====================================================
    // Shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access; the request stands for exactly the edge that takes it
    task automatic cfg(input logic is_rd, input logic [0:0] fn, input logic [7:0] a,
                       input logic [7:0] wd);
        @(posedge sys_clk);
        #1;
        req = '{func: fn, addr: a, wr: !is_rd, rd: is_rd, wdata: wd};
        @(posedge sys_clk);
        #1;
        req = '0;
    endtask

    task automatic rd_chk(input logic [0:0] fn, input logic [7:0] a, input logic [7:0] exp);
        cfg(1'b1, fn, a, 8'h00);
        chk("rvalid", rvalid, 16'h0001);
        chk("rdata", rdata, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // =====================================================
    // Scenarios
    task automatic test_reset();
        rd_chk(FUNC_ZERO, OFS_VIDEO_CTRL, RST_VIDEO_CTRL);
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, RST_LOADER_STAT);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, RST_PIN0_CTRL);
        rd_chk(FUNC_ZERO, 8'h86, UNMAPPED_READ);
        chk("zv_oe", zv_oe, 16'h0000);
        $display("test_reset done");
    endtask

    // Manual routing with no source present: select alone decides
    task automatic test_manual();
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'h81);
        cycles(3);
        chk("zv_out", zv_out, S0_PAT);
        chk("zv_oe", zv_oe, 16'h0001);
        chk("s0_oe", s0_oe, 16'h0000);
        chk("s1_oe", s1_oe, 16'h0001);
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'hc2);
        cycles(3);
        chk("zv_out", zv_out, S1_PAT);
        chk("s1_oe", s1_oe, 16'h0000);
        chk("s0_oe", s0_oe, 16'h0001);
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'h42);
        cycles(3);
        chk("zv_oe", zv_oe, 16'h0000);
        rd_chk(1'b1, OFS_VIDEO_CTRL, 8'h42);
        $display("test_manual done");
    endtask

    // Every defined priority code with all sources present; reserved codes stay unwritten
    task automatic test_auto();
        logic [15:0] exp;
        pres_cmd = 3'b111;
        cycles(6);
        for (int c = 0; c < 6; c++) begin
            cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, {3'b101, c[2:0], 2'b11});
            cycles(3);
            exp = (c < 2) ? S0_PAT : ((c < 4) ? S1_PAT : 16'h0000);
            chk("auto_out", zv_out, exp);
            chk("auto_oe", zv_oe, {15'h0, c < 4});
        end
        pres_cmd = 3'b110;
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'ha3);
        cycles(7);
        chk("auto_skip", zv_out, S1_PAT);
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'h83);
        cycles(3);
        chk("auto_off", zv_out, S0_PAT);
        $display("test_auto done");
    endtask

    task automatic test_loader();
        ee_present = 1'b1;
        ee_busy = 1'b1;
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, 8'h05);
        ee_error = 1'b1;
        cycles(1);
        ee_error = 1'b0;
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, 8'h07);
        cfg(1'b0, FUNC_ZERO, OFS_LOADER_STAT, 8'hfd);
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, 8'h07);
        cfg(1'b0, FUNC_ZERO, OFS_LOADER_STAT, 8'h02);
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, 8'h05);
        rd_chk(1'b1, OFS_LOADER_STAT, 8'h00);
        ee_present = 1'b0;
        ee_busy = 1'b0;
        rd_chk(FUNC_ZERO, OFS_LOADER_STAT, 8'h00);
        $display("test_loader done");
    endtask

    task automatic test_pin();
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'he6);
        cycles(8);
        chk("pin_oe", pin_oe, 16'h0001);
        chk("pin_out", pin_out, 16'h0001);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, 8'hc3);
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'hc0);
        cycles(8);
        chk("pin_out", pin_out, 16'h0000);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, 8'hc0);
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'h90);
        cycles(3);
        chk("pin_oe", pin_oe, 16'h0000);
        chk("csc", card_status_change, 16'h0000);
        pin_drive = 1'b1;
        pin_level = 1'b1;
        cycles(8);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, 8'h99);
        chk("csc", card_status_change, 16'h0001);
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'h98);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, 8'h91);
        chk("csc", card_status_change, 16'h0000);
        pin_drive = 1'b0;
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'h81);
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'h40);
        cycles(5);
        chk("pin_stat", pin_out, 16'h0001);
        // Video output off first, so a mode change that fails shows as a low pin
        activity = 1'b1;
        cfg(1'b0, FUNC_ZERO, OFS_VIDEO_CTRL, 8'h01);
        cfg(1'b0, FUNC_ZERO, OFS_PIN0_CTRL, 8'h00);
        cycles(3);
        chk("pin_act", pin_out, 16'h0001);
        chk("pin_oe", pin_oe, 16'h0001);
        $display("test_pin done");
    endtask

    // A second reset in mid-run brings the video control and pin 0 control defaults back
    task automatic test_rereset();
        rst = 1'b1;
        cycles(2);
        rst = 1'b0;
        rd_chk(FUNC_ZERO, OFS_VIDEO_CTRL, RST_VIDEO_CTRL);
        rd_chk(FUNC_ZERO, OFS_PIN0_CTRL, RST_PIN0_CTRL);
        $display("test_rereset done");
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // =====================================================
    // Clock, main sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        rst = 1'b1;
        req = '0;
        {ee_present, ee_error, ee_busy, activity, pin_drive, pin_level} = 6'h00;
        pres_cmd = 3'b000;
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        test_reset();
        test_manual();
        test_auto();
        test_loader();
        test_pin();
        test_rereset();
        final_report();
    end

    // The tests need under two hundred cycles; this leaves a wide margin
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
endmodule
